//--- verilog/pvdc_defs.vh
// Operation
// - Three modes: local, PC tool, remote
// - Mode set by tool or fieldbus object
// - Presets arrive as 10-bit conversions
// - Voltage unipolar; bipolar on two-solenoid only
// - Current range 0-20 or 4-20 mA
// - Cablebreak checked only on 4-20 mA, enabled
// - Cablebreak disables or fixes current, flags error
// - Detection takes about 100 ms
// - No current while not enabled
// - Tool may force enable
// - Two outputs, 1000 Hz PWM with dither
// - Status output: error, ready, 0, 1
// - Error latched until disable then enable
// - Default error setting, closed on error
// - Ready setting closes only without error
// - One-solenoid: 0-100% to A min-max
// - Two-solenoid unipolar split at 50%
// - Bipolar: negative to B, positive to A
// - Independent presets drive A and B
// - Mode change only while disabled
// - Over 90 C: error, block outputs
`ifndef PVDC_DEFS_VH
`define PVDC_DEFS_VH
// Register byte offsets
`define PVDC_REG_CTRL    12'h000
`define PVDC_REG_CFG     12'h004
`define PVDC_REG_IMIN    12'h008
`define PVDC_REG_IMAX    12'h00C
`define PVDC_REG_STATUS  12'h010
`define PVDC_REG_PRESET  12'h014
`define PVDC_REG_DUTY    12'h018
// CTRL fields
`define PVDC_CTRL_TOOLMODE 0
`define PVDC_CTRL_LOCAL    1
`define PVDC_CTRL_FORCEEN  2
`define PVDC_CTRL_TOOLEN   3
// CFG fields
`define PVDC_CFG_MAP_LO    0
`define PVDC_CFG_BIPOLAR   2
`define PVDC_CFG_CURRENT   3
`define PVDC_CFG_LIVEZERO  4
`define PVDC_CFG_CBEN      5
`define PVDC_CFG_CBFIX     6
`define PVDC_CFG_DOUT_LO   7
`define PVDC_CFG_TWOSOL    9
`define PVDC_CFG_FIX_LO    16
// Modes of operation
`define PVDC_MAP_UNI1      2'h0
`define PVDC_MAP_UNI2      2'h1
`define PVDC_MAP_BIP       2'h2
`define PVDC_MAP_INDEP     2'h3
// Status output settings
`define PVDC_DOUT_ERROR    2'h0
`define PVDC_DOUT_READY    2'h1
`define PVDC_DOUT_ZERO     2'h2
`define PVDC_DOUT_ONE      2'h3
// Reset values
`define PVDC_CFG_RST       32'h0000_0000
`define PVDC_IMIN_RST      10'h000
`define PVDC_IMAX_RST      10'h3FF
// Timing
`define PVDC_CLK_HZ        100000000
`define PVDC_PWM_HZ        1000
`define PVDC_PWM_CYC       (`PVDC_CLK_HZ / `PVDC_PWM_HZ)
`define PVDC_CB_MS         100
`define PVDC_CB_CYC        (`PVDC_CLK_HZ / 1000 * `PVDC_CB_MS)
// 4 mA point of a 0-20 mA code: 1023/5
`define PVDC_LIVEZERO_CODE 10'h0CC
`define PVDC_CB_CODE       10'h066
`define PVDC_TEMP_LIMIT    8'h5A
`endif

//--- verilog/pvdc_top.v
`timescale 1ns/1ps
`include "pvdc_defs.vh"
module pvdc_top #(
    parameter PWM_CYC = `PVDC_PWM_CYC,
    parameter CB_CYC  = `PVDC_CB_CYC
) (
    // Clock and reset
    input  wire        clock,
    input  wire        resetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Converted presets, temperature, enable pin
    input  wire [9:0]  preset1,
    input  wire [9:0]  preset2,
    input  wire [7:0]  tempC,
    input  wire        enableIn,
    // Fieldbus local-operation object write
    input  wire        busLocalWr,
    input  wire        busLocalVal,
    // Outputs
    output reg         pwmA_r,
    output reg         pwmB_r,
    output reg         statusSwitch_r,
    output reg  [1:0]  opMode_r
);
    localparam MODE_LOCAL  = 2'h1;
    localparam MODE_TOOL   = 2'h2;
    localparam MODE_REMOTE = 2'h0;
    localparam ST_DIS = 2'b01;
    localparam ST_ACT = 2'b10;

    // Software-visible registers
    reg [3:0]  ctrl_r;
    reg [31:0] cfg_r;
    reg [9:0]  iMin_r;
    reg [9:0]  iMax_r;
    // Enable state and latched errors
    reg [1:0]  state_r;
    reg        err_r;
    reg        cbErr_r;
    reg        tempErr_r;
    // Cablebreak filter and PWM timing
    reg [26:0] cbCnt_r;
    reg [16:0] pwmCnt_r;
    reg [4:0]  dither_r;
    // Setpoints and mapping scratch
    reg [9:0]  setA_r;
    reg [9:0]  setB_r;
    reg [9:0]  dutyA;
    reg [9:0]  dutyB;
    reg [10:0] posA;
    reg [10:0] posB;
    reg [9:0]  fixCur;
    reg [31:0] rdNext;
    // Duty compare results, registered below
    wire       pwmOnA;
    wire       pwmOnB;

    wire [1:0] mapMode  = cfg_r[`PVDC_CFG_MAP_LO+1:`PVDC_CFG_MAP_LO];
    wire [1:0] doutMode = cfg_r[`PVDC_CFG_DOUT_LO+1:`PVDC_CFG_DOUT_LO];
    wire       twoSol   = cfg_r[`PVDC_CFG_TWOSOL];
    wire       liveZero = cfg_r[`PVDC_CFG_CURRENT] & cfg_r[`PVDC_CFG_LIVEZERO];
    wire       apbWr    = psel & penable & pwrite & pready;
    wire       apbAcc   = psel & penable & pready;
    // Enable source: pin in local mode, tool flag otherwise, or forced
    wire       enReq    = ctrl_r[`PVDC_CTRL_FORCEEN] |
                          ((opMode_r == MODE_LOCAL) ? enableIn : ctrl_r[`PVDC_CTRL_TOOLEN]);
    wire       active   = (state_r == ST_ACT);
    wire       cbWatch  = liveZero & cfg_r[`PVDC_CFG_CBEN];

    // Linear map of one preset onto min..max current
    function [9:0] lerp;
        input [9:0] pos;
        input [9:0] lo;
        input [9:0] hi;
        reg   [20:0] prod;
        begin
            prod = {11'h000, pos} * ({1'b0, hi} - {1'b0, lo});
            lerp = lo + prod[19:10];
        end
    endfunction

    // Preset scaled to 0..1023 over its span, live zero removed
    function [9:0] span;
        input [9:0] raw;
        input       lz;
        reg   [19:0] p;
        begin
            p = 20'h00000;
            if (!lz) begin
                span = raw;
            end else if (raw <= `PVDC_LIVEZERO_CODE) begin
                span = 10'h000;
            end else begin
                // Span above live zero stretched by 5/4 to full scale
                p    = {10'h000, raw - `PVDC_LIVEZERO_CODE} * 20'h00500;
                span = (p[19:10] > 10'h3FF) ? 10'h3FF : p[19:10];
            end
        end
    endfunction

    // APB: zero wait state, unmapped address answers with error
    always @(posedge clock) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            // Setup cycle loads read data and the error answer
            if (psel & ~penable) begin
                prdata <= rdNext;
                pslverr <= (paddr > `PVDC_REG_DUTY) | (paddr[1:0] != 2'h0);
            end
        end
    end

    // Read mux
    always @* begin
        case (paddr)
            `PVDC_REG_CTRL:   rdNext = {28'h0, ctrl_r};
            `PVDC_REG_CFG:    rdNext = cfg_r;
            `PVDC_REG_IMIN:   rdNext = {22'h0, iMin_r};
            `PVDC_REG_IMAX:   rdNext = {22'h0, iMax_r};
            `PVDC_REG_STATUS: rdNext = {24'h0, tempErr_r, cbErr_r, err_r, active,
                                        statusSwitch_r, 1'b0, opMode_r};
            `PVDC_REG_PRESET: rdNext = {6'h0, preset2, 6'h0, preset1};
            `PVDC_REG_DUTY:   rdNext = {6'h0, setB_r, 6'h0, setA_r};
            default:          rdNext = 32'h0000_0000;
        endcase
    end

    // Register writes; mode and configuration locked while active
    always @(posedge clock) begin
        if (!resetn) begin
            ctrl_r   <= 4'h0;
            cfg_r    <= `PVDC_CFG_RST;
            iMin_r   <= `PVDC_IMIN_RST;
            iMax_r   <= `PVDC_IMAX_RST;
            opMode_r <= MODE_LOCAL;
        end else begin
            if (apbWr && paddr == `PVDC_REG_CTRL) begin
                // Mode command bits self-clear; only the enables are kept
                ctrl_r <= {pwdata[3:2], 2'b00};
                if (!active && pwdata[`PVDC_CTRL_TOOLMODE])
                    opMode_r <= MODE_TOOL;
                else if (!active && pwdata[`PVDC_CTRL_LOCAL])
                    opMode_r <= MODE_LOCAL;
            end else if (busLocalWr && !active) begin
                opMode_r <= busLocalVal ? MODE_LOCAL : MODE_REMOTE;
            end
            if (apbWr && paddr == `PVDC_REG_CFG && !active) begin
                cfg_r <= pwdata;
                // Bipolar only on two-solenoid build
                if (!pwdata[`PVDC_CFG_TWOSOL]) begin
                    cfg_r[`PVDC_CFG_BIPOLAR] <= 1'b0;
                    cfg_r[`PVDC_CFG_MAP_LO+1:`PVDC_CFG_MAP_LO] <= `PVDC_MAP_UNI1;
                end
            end
            if (apbWr && paddr == `PVDC_REG_IMIN)
                iMin_r <= pwdata[9:0];
            if (apbWr && paddr == `PVDC_REG_IMAX)
                iMax_r <= pwdata[9:0];
        end
    end

    // Disabled / active state
    always @(posedge clock) begin
        if (!resetn) begin
            state_r <= ST_DIS;
        end else begin
            case (state_r)
                ST_DIS:  if (enReq) state_r <= ST_ACT;
                ST_ACT:  if (!enReq) state_r <= ST_DIS;
                default: state_r <= ST_DIS;
            endcase
        end
    end

    // Cablebreak filter and latched errors
    always @(posedge clock) begin
        if (!resetn) begin
            cbCnt_r   <= 27'h0;
            cbErr_r   <= 1'b0;
            tempErr_r <= 1'b0;
            err_r     <= 1'b0;
        end else begin
            // Counter saturates so a lasting break keeps the flag set
            if (cbWatch && preset2 < `PVDC_CB_CODE) begin
                if (cbCnt_r < CB_CYC[26:0] - 27'h1)
                    cbCnt_r <= cbCnt_r + 27'h1;
            end else begin
                cbCnt_r <= 27'h0;
            end
            // Set wins over the disable clear
            if (!enReq && !active) begin
                cbErr_r   <= 1'b0;
                tempErr_r <= 1'b0;
            end
            if (cbWatch && cbCnt_r == CB_CYC[26:0] - 27'h1)
                cbErr_r <= 1'b1;
            if (tempC > `PVDC_TEMP_LIMIT)
                tempErr_r <= 1'b1;
            err_r <= cbErr_r | tempErr_r;
        end
    end

    // Setpoint mapping per mode of operation
    always @* begin
        posA   = 11'h000;
        posB   = 11'h000;
        fixCur = cfg_r[`PVDC_CFG_FIX_LO+9:`PVDC_CFG_FIX_LO];
        case (mapMode)
            `PVDC_MAP_UNI1: begin
                posA = {1'b0, span(cfg_r[`PVDC_CFG_CURRENT] ? preset2 : preset1, liveZero)};
            end
            `PVDC_MAP_UNI2: begin
                posA = {1'b0, span(cfg_r[`PVDC_CFG_CURRENT] ? preset2 : preset1, liveZero)};
                if (posA[9]) begin
                    // Upper half: A rises from minimum to full scale
                    posA = {1'b0, posA[8:0], 1'b1};
                    posB = 11'h000;
                end else begin
                    // Lower half: B falls from full scale to minimum
                    posB = {1'b0, ~posA[8:0], 1'b1};
                    posA = 11'h000;
                end
            end
            `PVDC_MAP_BIP: begin
                // Signed preset: bit 9 is sign, two's complement
                if (preset1[9]) begin
                    // Inverse of a negative code is its magnitude less one
                    posB = {1'b0, ~preset1[8:0], 1'b1};
                end else begin
                    posA = {1'b0, preset1[8:0], preset1[8]};
                end
            end
            `PVDC_MAP_INDEP: begin
                posA = {1'b0, span(preset1, 1'b0)};
                posB = {1'b0, span(preset2, liveZero)};
            end
            default: begin
                posA = 11'h000;
            end
        endcase
        dutyA = (posA == 11'h000) ? 10'h000 : lerp(posA[9:0], iMin_r, iMax_r);
        dutyB = (posB == 11'h000) ? 10'h000 : lerp(posB[9:0], iMin_r, iMax_r);
        if (!twoSol)
            dutyB = 10'h000;
    end

    // Setpoint register with enable, error and cablebreak gating
    always @(posedge clock) begin
        if (!resetn) begin
            setA_r <= 10'h000;
            setB_r <= 10'h000;
        end else if (!active || tempErr_r) begin
            setA_r <= 10'h000;
            setB_r <= 10'h000;
        end else if (cbErr_r) begin
            setA_r <= cfg_r[`PVDC_CFG_CBFIX] ? fixCur : 10'h000;
            setB_r <= (cfg_r[`PVDC_CFG_CBFIX] && twoSol) ? fixCur : 10'h000;
        end else begin
            setA_r <= dutyA;
            setB_r <= dutyB;
        end
    end

    // One duty compare per solenoid channel
    pvdc_pwm_cmp #(
        .PWM_CYC  (PWM_CYC)
    ) i_pvdc_pwm_cmp_a (
        .pwmCnt   (pwmCnt_r),
        .ditherHi (dither_r[4]),
        .setpoint (setA_r),
        .pwmOn    (pwmOnA)
    );

    pvdc_pwm_cmp #(
        .PWM_CYC  (PWM_CYC)
    ) i_pvdc_pwm_cmp_b (
        .pwmCnt   (pwmCnt_r),
        .ditherHi (dither_r[4]),
        .setpoint (setB_r),
        .pwmOn    (pwmOnB)
    );

    // 1000 Hz PWM, dither steps each period
    always @(posedge clock) begin
        if (!resetn) begin
            pwmCnt_r <= 17'h0;
            dither_r <= 5'h00;
            pwmA_r   <= 1'b0;
            pwmB_r   <= 1'b0;
        end else begin
            if (pwmCnt_r == PWM_CYC[16:0] - 17'h1) begin
                pwmCnt_r <= 17'h0;
                dither_r <= dither_r + 5'h01;
            end else begin
                pwmCnt_r <= pwmCnt_r + 17'h1;
            end
            pwmA_r <= pwmOnA;
            pwmB_r <= pwmOnB;
        end
    end

    // Low-side switch: high means closed to ground
    always @(posedge clock) begin
        if (!resetn) begin
            statusSwitch_r <= 1'b0;
        end else begin
            case (doutMode)
                `PVDC_DOUT_ERROR: statusSwitch_r <= err_r;
                `PVDC_DOUT_READY: statusSwitch_r <= ~err_r;
                `PVDC_DOUT_ZERO:  statusSwitch_r <= 1'b0;
                `PVDC_DOUT_ONE:   statusSwitch_r <= 1'b1;
                default:          statusSwitch_r <= err_r;
            endcase
        end
    end
endmodule // pvdc_top

// Duty compare of one channel against the shared period counter
module pvdc_pwm_cmp #(
    parameter PWM_CYC = `PVDC_PWM_CYC
) (
    // Shared period counter and dither phase
    input  wire [16:0] pwmCnt,
    input  wire        ditherHi,
    // Channel setpoint, 1/1024 of a period per code
    input  wire [9:0]  setpoint,
    // Compare result, registered by the caller
    output wire        pwmOn
);
    wire [10:0] level;
    wire [27:0] scaled;
    wire [16:0] threshold;

    // Dither lifts the level by eight codes for 16 periods out of every 32
    assign level     = {1'b0, setpoint} + (ditherHi ? 11'h000 : 11'h008);
    // Scale to the period; wide product so full scale never wraps
    assign scaled    = {17'h00000, level} * {11'h000, PWM_CYC[16:0]};
    assign threshold = scaled[26:10];
    // Zero setpoint means no current at all, dither or not
    assign pwmOn     = (setpoint != 10'h000) && (pwmCnt < threshold);
endmodule // pvdc_pwm_cmp

//--- dv/pvdc_top_assertions.sv
`timescale 1ns/1ps
module pvdc_top_assertions (
    // Clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Device side
    input wire logic [7:0]  tempC,
    input wire logic        pwmA_r,
    input wire logic        pwmB_r,
    input wire logic [1:0]  opMode_r
);
    // One clock domain throughout
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Bus answer timing and error flag
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    AST_ERR_MAP: assert property (pready && (paddr > 12'h018 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not flagged");
    AST_OK_MAP: assert property (pready && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error flag without answer");
    // Device behaviour
    AST_HOT_OFF: assert property (tempC > 8'h5A [*4] |-> !pwmA_r && !pwmB_r)
        else $error("current while overheated");
    AST_MODE_HOLD: assert property ($changed(opMode_r) |=> !pwmA_r && !pwmB_r)
        else $error("mode changed while active");
    AST_MODE_LEGAL: assert property (opMode_r != 2'h3)
        else $error("illegal mode");

    // Main scenarios
    cover property (pready && pslverr);
    cover property (tempC > 8'h5A && !pwmA_r);
    cover property (!$stable(opMode_r));
endmodule // pvdc_top_assertions

//--- dv/pvdc_plc_model.sv
`timescale 1ns/1ps
module pvdc_plc_model (
    // Switch and chosen setting
    input  wire logic statusSwitch,
    input  wire logic readyMode,
    // What the controller reads
    output logic      plcIn,
    output logic      plcError
);
    // Pull-up input: a closed switch reads 0
    assign plcIn = !statusSwitch;
    // Reading depends on the setting
    assign plcError = readyMode ? plcIn : !plcIn;
endmodule // pvdc_plc_model

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int PWM = 1280;
    localparam int CB = 20;
    logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, pwmA_r, pwmB_r, statusSwitch_r, er, plcError;
    logic [1:0]  opMode_r;
    logic [9:0]  preset1 = 10'h000, preset2 = 10'h200, p;
    logic [7:0]  tempC = 8'h19;
    logic        enableIn = 0, busLocalWr = 0, busLocalVal = 0, readyMode = 0;
    int          n_errors = 0, checks_done = 0, ha, hb, seed = 55507;

    // Device and controller model
    pvdc_top #(.PWM_CYC(PWM), .CB_CYC(CB)) i_pvdc_top (.clock, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .preset1, .preset2, .tempC,
        .enableIn, .busLocalWr, .busLocalVal, .pwmA_r, .pwmB_r, .statusSwitch_r, .opMode_r);
    pvdc_plc_model i_pvdc_plc_model (.statusSwitch(statusSwitch_r), .readyMode, .plcIn(),
        .plcError);

    // Clock
    always #5 clock = ~clock;

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask

    // One bus transfer, waits for the answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        cyc(2);
    endtask

    // Fieldbus local-object write
    task automatic bus(input logic v);
        @(posedge clock);
        busLocalWr <= 1;
        busLocalVal <= v;
        @(posedge clock);
        busLocalWr <= 0;
        cyc(2);
    endtask

    // High cycles over one period after settling
    task automatic meas();
        cyc(PWM);
        ha = 0;
        hb = 0;
        repeat (PWM) begin
            @(posedge clock);
            ha += pwmA_r;
            hb += pwmB_r;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        #600_000;
        n_errors++;
        results();
    end

    // Test sequence
    initial begin
        cyc(12);
        resetn <= 1;
        cyc(2);
        chk("mode", 1, opMode_r);
        chk("switch", 0, statusSwitch_r);
        apb(0, 12'h004, 0);
        chk("cfg", 0, rd);
        apb(0, 12'h01C, 0);
        chk("slverr", 1, er);
        $display("reset test done");
        bus(0);
        chk("mode", 0, opMode_r);
        apb(1, 12'h000, 1);
        chk("mode", 2, opMode_r);
        apb(1, 12'h000, 2);
        chk("mode", 1, opMode_r);
        preset1 <= 10'h3FF;
        meas();
        chk("offA", 0, ha);
        $display("mode test done");
        enableIn <= 1;
        meas();
        chk("onA", 1, ha > 0);
        chk("offB", 0, hb);
        apb(1, 12'h000, 1);
        bus(0);
        chk("mode", 1, opMode_r);
        enableIn <= 0;
        apb(1, 12'h000, 4);
        meas();
        chk("force", 1, ha > 0);
        apb(1, 12'h000, 0);
        $display("enable test done");
        apb(1, 12'h004, 32'h0000_0006);
        apb(0, 12'h004, 0);
        chk("cfg", 0, rd);
        apb(1, 12'h004, 32'h0000_0201);
        enableIn <= 1;
        repeat (4) begin
            p = {$random(seed)} % 32'h180;
            if ($random(seed) & 1)
                p = 10'h3FF - p;
            preset1 <= p;
            meas();
            chk("sideA", p > 10'h1FF, ha > hb);
        end
        enableIn <= 0;
        apb(1, 12'h004, 32'h0000_0206);
        enableIn <= 1;
        preset1 <= 10'h200;
        meas();
        chk("bipB", 1, hb > ha);
        enableIn <= 0;
        apb(1, 12'h004, 32'h0000_0203);
        enableIn <= 1;
        preset1 <= 10'h3FF;
        preset2 <= 10'h3FF;
        meas();
        chk("indepA", 1, ha > 0);
        chk("indepB", 1, hb > 0);
        $display("mapping test done");
        enableIn <= 0;
        for (int s = 0; s < 4; s++) begin
            readyMode <= s[0];
            apb(1, 12'h004, s << 7);
            chk("switch", s & 1, statusSwitch_r);
            chk("plc", 0, plcError);
        end
        readyMode <= 0;
        apb(1, 12'h004, 0);
        enableIn <= 1;
        preset1 <= 10'h200;
        meas();
        chk("halfA", 1, ha > PWM * 2 / 5 && ha < PWM * 3 / 5);
        tempC <= 8'h5A;
        cyc(8);
        chk("switch", 0, statusSwitch_r);
        tempC <= 8'h5B;
        meas();
        chk("hotA", 0, ha);
        chk("switch", 1, statusSwitch_r);
        chk("plc", 1, plcError);
        tempC <= 8'h19;
        cyc(8);
        chk("latch", 1, statusSwitch_r);
        enableIn <= 0;
        cyc(4);
        enableIn <= 1;
        cyc(4);
        chk("clear", 0, statusSwitch_r);
        $display("status test done");
        enableIn <= 0;
        apb(1, 12'h004, 32'h0200_0078);
        enableIn <= 1;
        preset2 <= 10'h050;
        cyc(CB / 2);
        chk("early", 0, statusSwitch_r);
        cyc(CB);
        chk("break", 1, statusSwitch_r);
        meas();
        chk("fixA", 1, ha > 0);
        enableIn <= 0;
        apb(1, 12'h004, 32'h0000_0018);
        enableIn <= 1;
        cyc(3 * CB);
        chk("cbOff", 0, statusSwitch_r);
        $display("break test done");
        results();
    end
endmodule // tb

bind pvdc_top pvdc_top_assertions i_chk (.clock, .resetn, .psel, .penable, .paddr, .pready,
    .pslverr, .tempC, .pwmA_r, .pwmB_r, .opMode_r);
